// ---- flash_front.sv ----
// Serial flash front end: pin sampling, command decode, status and hold
// Function
// - Capture input bits on rising serial clock
// - Change output bits after falling serial clock
// - Start new command only on select falling
// - Accept clock idle low and idle high
// - Output pin shows busy during auto-increment
// - Pause suspends without losing command state
// - Protect pin gates the lockdown bit
// - Erase in 4K sectors, 32K, 64K blocks
// - Busy flag readable for end-of-write polling
// - Status bit 0 is busy
// - Deselect during pause resets interface logic
// - Lockdown blocks status writes only when protected
`timescale 1ns/100ps
`default_nettype none
module flash_front (
    input wire logic clk, // 20 MHz system clock
    input wire logic rstn, // Synchronous reset, active low
    input wire logic sck, // Serial clock pin
    input wire logic si, // Serial data in pin
    input wire logic ce_n, // Chip select pin, active low
    input wire logic hold_n, // Pause pin, active low
    input wire logic wp_n, // Write protect pin, active low
    output logic so, // Serial data out
    output logic so_oe, // Serial out enable
    input wire logic busy_in, // Array operation running
    output logic op_valid, // Operation available
    input wire logic op_ready, // Array takes operation
    output flash_front_pkg::op_t op_data, // Operation word
    output logic [7:0] status // Registered status byte
);
    import flash_front_pkg::*;

    typedef enum {S_IDLE, S_OPC, S_ADDR, S_DATA, S_WRSR, S_RDSR, S_SKIP} state_t;

    // ************************************************
    // Pin synchronisers
    // ************************************************
    logic [4:0] pin_m, pin_s;
    logic sck_d, ce_d;
    // Two flops per pin; only the second stage is looked at
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pin_m <= 5'h1f;
            pin_s <= 5'h1f;
        end else begin
            pin_m <= {wp_n, hold_n, ce_n, si, sck};
            pin_s <= pin_m;
        end
    end
    wire sck_s = pin_s[0];
    wire si_s = pin_s[1];
    wire ce_s = pin_s[2];
    wire hold_s = pin_s[3];
    wire wp_s = pin_s[4];
    // Edge history of synchronised levels
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sck_d <= 1'b1; // Same level as the synchroniser reset, so no edge is invented
            ce_d <= 1'b1;
        end else begin
            sck_d <= sck_s;
            ce_d <= ce_s;
        end
    end

    // ************************************************
    // Hold and selection
    // ************************************************
    logic held, lock;
    // Pause changes only while clock is low, so no edge is split
    always_ff @(posedge clk) begin
        if (!rstn) begin
            held <= 1'b0;
        end else if (!sck_s) begin
            held <= ~hold_s;
        end
    end
    // Deselect during pause locks out until pause is released
    always_ff @(posedge clk) begin
        if (!rstn) begin
            lock <= 1'b0;
        end else if (ce_s && held) begin
            lock <= 1'b1;
        end else if (hold_s) begin
            lock <= 1'b0;
        end
    end
    // Edges are counted the same whatever level the clock idles at
    wire active = !ce_s && !held && !lock;
    wire rise = active && sck_s && !sck_d;
    wire fall = active && !sck_s && sck_d;
    wire start = ce_d && !ce_s && hold_s && !lock;

    // ************************************************
    // Command engine
    // ************************************************
    state_t st;
    logic [2:0] bitcnt, idx;
    logic [6:0] shreg;
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [1:0] bytecnt;
    logic wel, auto_increment_program, ebsy, protect_lockdown_bit;
    logic [3:0] bp;
    logic fifo_room;
    wire byte_done = rise && bitcnt == 3'h7;
    wire [7:0] rx = {shreg, si_s};
    wire rx_auto = rx == OP_AUTO_INCREMENT_PROGRAM;
    wire [7:0] sr = {protect_lockdown_bit, auto_increment_program, bp, wel, busy_in};
    wire sr_write_ok = wel && (wp_s || !protect_lockdown_bit);
    wire mem_ok = wel && !busy_in && op_ready && fifo_room; // Full FIFO refuses the command
    wire is_erase = opcode == OP_SECT || opcode == OP_BLK32 || opcode == OP_BLK64;
    wire busy_pin = auto_increment_program && ebsy && active && st != S_RDSR;

    // Align an address down to the erase unit of a kind
    function automatic logic [23:0] align(input logic [23:0] a, input op_kind_t k);
        logic [23:0] m;
        m = 24'hffffff;
        unique case (k)
            K_SECT: m = ~24'(SECTOR_BYTES - 1);
            K_BLK32: m = ~24'(BLOCK32_BYTES - 1);
            K_BLK64: m = ~24'(BLOCK64_BYTES - 1);
            K_CHIP: m = 24'h000000;
            K_PROG: m = 24'hffffff;
        endcase
        return a & m;
    endfunction

    // Operation push towards the array
    op_kind_t kind;
    logic push;
    op_t push_op;
    assign kind = opcode == OP_SECT ? K_SECT : opcode == OP_BLK32 ? K_BLK32 :
                  opcode == OP_BLK64 ? K_BLK64 : K_PROG;
    wire push_chip = st == S_OPC && byte_done && rx == OP_CHIP && mem_ok && bp == 4'h0;
    wire push_erase = st == S_ADDR && byte_done && bytecnt == 2'h2 && is_erase;
    wire push_prog = st == S_DATA && byte_done;
    assign push = push_chip || push_erase || push_prog;
    assign push_op.kind = push_chip ? K_CHIP : push_prog ? K_PROG : kind;
    assign push_op.addr = align(push_erase ? {addr[15:0], rx} : addr, push_op.kind);
    assign push_op.data = rx;

    // Bit counter and input shifter
    always_ff @(posedge clk) begin
        if (!rstn || ce_s || start) begin
            bitcnt <= 3'h0;
            shreg <= 7'h00;
        end else if (rise) begin
            bitcnt <= bitcnt + 3'h1;
            shreg <= rx[6:0];
        end
    end

    // Command sequencing; deselect always returns to idle
    always_ff @(posedge clk) begin
        if (!rstn || ce_s) begin
            st <= S_IDLE;
            bytecnt <= 2'h0;
        end else if (start) begin
            st <= S_OPC;
            bytecnt <= 2'h0;
        end else if (byte_done) begin
            unique case (st)
                S_OPC: begin
                    opcode <= rx;
                    if (rx == OP_RDSR) st <= S_RDSR;
                    else if (rx == OP_WRSR) st <= S_WRSR;
                    else if (rx_auto && auto_increment_program && mem_ok) st <= S_DATA;
                    else if ((rx_auto || rx == OP_PROG) && mem_ok && !auto_increment_program)
                        st <= S_ADDR;
                    else if ((rx == OP_SECT || rx == OP_BLK32 || rx == OP_BLK64) && mem_ok)
                        st <= S_ADDR;
                    else st <= S_SKIP;
                end
                S_ADDR: begin
                    addr <= {addr[15:0], rx};
                    bytecnt <= bytecnt + 2'h1;
                    if (bytecnt == 2'h2) st <= is_erase ? S_SKIP : S_DATA;
                end
                S_DATA: begin
                    addr <= addr + 24'h1;
                    st <= S_SKIP;
                end
                default: st <= S_SKIP;
            endcase
        end
    end

    // Write enable, auto-increment mode, busy-out enable
    always_ff @(posedge clk) begin
        if (!rstn) begin
            wel <= 1'b0;
            auto_increment_program <= 1'b0;
            ebsy <= 1'b0;
        end else if (st == S_OPC && byte_done) begin
            if (rx == OP_WREN) wel <= 1'b1;
            if (rx == OP_WRDI) wel <= 1'b0;
            if (rx == OP_WRDI) auto_increment_program <= 1'b0;
            if (rx == OP_EBSY) ebsy <= 1'b1;
            if (rx == OP_DBSY) ebsy <= 1'b0;
            if (push_chip) wel <= 1'b0;
        end else if (push_erase || (st == S_WRSR && byte_done)) begin
            wel <= 1'b0;
        end else if (push_prog) begin
            if (opcode == OP_AUTO_INCREMENT_PROGRAM) auto_increment_program <= 1'b1;
            else wel <= 1'b0;
        end
    end

    // Protection bits, written only when the lockdown permits
    always_ff @(posedge clk) begin
        if (!rstn) begin
            bp <= BP_RESET;
            protect_lockdown_bit <= 1'b0;
        end else if (st == S_WRSR && byte_done && sr_write_ok) begin
            bp <= rx[SR_BP_LO +: 4];
            protect_lockdown_bit <= rx[SR_PROTECT_LOCKDOWN_BIT];
        end
    end

    // Status copy for polling on the user side
    always_ff @(posedge clk) begin
        if (!rstn) begin
            status <= 8'h00;
        end else begin
            status <= sr;
        end
    end

    // ************************************************
    // Serial output
    // ************************************************
    // Status bits leave after falling edges, repeating while selected;
    // pin sync adds about three clocks, so serial clock must stay slow
    always_ff @(posedge clk) begin
        if (!rstn) begin
            so <= 1'b0;
            idx <= 3'h7;
        end else if (st != S_RDSR) begin
            idx <= 3'h7;
            if (busy_pin) so <= ~busy_in;
        end else if (fall) begin
            so <= sr[idx];
            idx <= idx - 3'h1;
        end
    end
    assign so_oe = active && (st == S_RDSR || busy_pin);

    op_fifo #(.WIDTH($bits(op_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rstn(rstn),
        .in_valid(push),
        .in_ready(fifo_room),
        .in_data(push_op),
        .out_valid(op_valid),
        .out_ready(op_ready),
        .out_data(op_data)
    );

    // ************************************************
    // Checks
    // ************************************************
    deselect_hiz_a: assert property (@(posedge clk) disable iff (!rstn)
        ce_s |-> !so_oe) else $error("output driven while deselected");
    select_start_a: assert property (@(posedge clk) disable iff (!rstn)
        start |=> st == S_OPC && bitcnt == 3'h0) else $error("select did not start");
    deselect_idle_a: assert property (@(posedge clk) disable iff (!rstn)
        ce_s |=> st == S_IDLE) else $error("deselect left command open");
    shift_rise_a: assert property (@(posedge clk) disable iff (!rstn)
        !rise && !ce_s && !start |=> $stable(shreg)) else $error("shift without rising edge");
    out_fall_a: assert property (@(posedge clk) disable iff (!rstn)
        st == S_RDSR && !fall ##1 st == S_RDSR |-> $stable(so)) else $error("so moved off edge");
    pause_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        held && !ce_s |-> !so_oe ##1 ($stable(st) && $stable(bitcnt)))
        else $error("pause lost state");
    pause_drop_a: assert property (@(posedge clk) disable iff (!rstn)
        ce_s && held |=> lock && st == S_IDLE) else $error("deselect in pause kept state");
    lock_protect_a: assert property (@(posedge clk) disable iff (!rstn)
        st == S_WRSR && byte_done && !wp_s && protect_lockdown_bit
        |=> $stable(bp) && protect_lockdown_bit)
        else $error("locked status written");
    busy_flag_a: assert property (@(posedge clk) disable iff (!rstn)
        ##1 status[SR_BUSY] == $past(busy_in)) else $error("busy bit wrong");
    busy_pin_a: assert property (@(posedge clk) disable iff (!rstn)
        busy_pin ##1 st != S_RDSR |-> so == !$past(busy_in)) else $error("busy pin wrong");
    erase_align_a: assert property (@(posedge clk) disable iff (!rstn)
        push && push_op.kind == K_SECT |-> push_op.addr[11:0] == 12'h000)
        else $error("sector not aligned");
endmodule
`default_nettype wire

// ---- flash_front_pkg.sv ----
// Shared constants and types for the serial flash front end
package flash_front_pkg;
    // Command opcodes
    localparam logic [7:0] OP_RDSR = 8'h05;
    localparam logic [7:0] OP_WRSR = 8'h01;
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_PROG = 8'h02;
    localparam logic [7:0] OP_AUTO_INCREMENT_PROGRAM = 8'had;
    localparam logic [7:0] OP_SECT = 8'h20;
    localparam logic [7:0] OP_BLK32 = 8'h52;
    localparam logic [7:0] OP_BLK64 = 8'hd8;
    localparam logic [7:0] OP_CHIP = 8'h60;
    localparam logic [7:0] OP_EBSY = 8'h70;
    localparam logic [7:0] OP_DBSY = 8'h80;
    // Erase granularity in bytes
    localparam int SECTOR_BYTES = 4096;
    localparam int BLOCK32_BYTES = 32768;
    localparam int BLOCK64_BYTES = 65536;
    // Status bit positions and reset value
    localparam int SR_BUSY = 0;
    localparam int SR_WEL = 1;
    localparam int SR_BP_LO = 2;
    localparam int SR_AUTO_INCREMENT_PROGRAM = 6;
    localparam int SR_PROTECT_LOCKDOWN_BIT = 7;
    localparam logic [3:0] BP_RESET = 4'h7;
    localparam int FIFO_DEPTH = 16;
    // Operations handed to the array side
    typedef enum logic [2:0] {K_PROG, K_SECT, K_BLK32, K_BLK64, K_CHIP} op_kind_t;
    typedef struct packed {
        op_kind_t kind;
        logic [23:0] addr;
        logic [7:0] data;
    } op_t;
endpackage

// ---- op_fifo.sv ----
// Synchronous valid/ready FIFO for array operations
`timescale 1ns/100ps
`default_nettype none
module op_fifo #(
    parameter int WIDTH = 35,
    parameter int DEPTH = 16
) (
    input wire logic clk, // System clock
    input wire logic rstn, // Synchronous reset, active low
    input wire logic in_valid, // Write request
    output logic in_ready, // Space available
    input wire logic [WIDTH-1:0] in_data, // Write word
    output logic out_valid, // Word available
    input wire logic out_ready, // Consumer takes word
    output logic [WIDTH-1:0] out_data // Head word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp, rp;
    logic [AW:0] count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    // Honest flags from the occupancy count
    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rp];
    // Storage write
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp] <= in_data;
        end
    end
    // Pointers and count
    always_ff @(posedge clk) begin
        if (!rstn) begin
            wp <= '0;
            rp <= '0;
            count <= '0;
        end else begin
            if (push) wp <= wp + 1'b1;
            if (pop) rp <= rp + 1'b1;
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// ---- spi_host.sv ----
// Bus master model that drives the serial pins of the flash front end
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Serial bus master
// ****************************************
module spi_host (
    input wire logic clk, // System clock
    input wire logic so, // Data from the memory
    output logic sck, // Serial clock
    output logic si, // Data to the memory
    output logic ce_n, // Select, active low
    output logic hold_n // Pause, active low
);
    // Half period well above the sync delay so every edge is seen
    localparam int HALF = 10;
    logic idle = 1'b0; // Clock level outside frames
    // Pins start idle and deselected
    initial begin
        sck = 1'b0;
        si = 1'b0;
        ce_n = 1'b1;
        hold_n = 1'b1;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Mode is only changed while deselected
    task automatic set_mode(input logic lvl);
        idle = lvl;
        sck <= lvl;
        wait_clk(HALF);
    endtask
    // Select stays low from first bit to last bit
    task automatic open_frame();
        ce_n <= 1'b0;
        wait_clk(HALF);
    endtask
    // Data line is flipped after release so stale bits never look valid
    task automatic close_frame();
        sck <= idle;
        wait_clk(HALF);
        ce_n <= 1'b1;
        si <= ~si;
        wait_clk(HALF);
    endtask
    // Msb first: new bit on the falling edge, returned bit read before rising
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sck <= 1'b0;
            si <= tx[i];
            wait_clk(HALF);
            rx[i] = so;
            sck <= 1'b1;
            wait_clk(HALF);
        end
    endtask
    // Pause is entered and left only while the clock is low
    task automatic pause_on();
        sck <= 1'b0;
        wait_clk(HALF);
        hold_n <= 1'b0;
        wait_clk(HALF);
    endtask
    task automatic pause_off();
        sck <= 1'b0;
        wait_clk(HALF);
        hold_n <= 1'b1;
        wait_clk(HALF);
    endtask
endmodule
`default_nettype wire

// ---- serial_flash_spi_front_end_tb.sv ----
// Self-checking testbench for the flash front end
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Testbench top
// ****************************************
module serial_flash_spi_front_end_tb;
    import flash_front_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic wp_n = 1'b1;
    logic busy_in = 1'b0;
    logic op_ready = 1'b1;
    wire sck, si, ce_n, hold_n, so, so_oe, op_valid;
    // Released line shows the opposite of the last bit, so a late enable is caught
    wire so_line = so_oe ? so : ~so;
    op_t op_data;
    op_t last_op;
    logic [7:0] status;
    logic [7:0] rx;
    int got_ops = 0;
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [7:0] eop [3] = '{OP_SECT, OP_BLK32, OP_BLK64};
    op_kind_t ek [3] = '{K_SECT, K_BLK32, K_BLK64};
    int esz [3] = '{SECTOR_BYTES, BLOCK32_BYTES, BLOCK64_BYTES};

    flash_front DUT (.clk(clk), .rstn(rstn), .sck(sck), .si(si), .ce_n(ce_n),
        .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe), .busy_in(busy_in),
        .op_valid(op_valid), .op_ready(op_ready), .op_data(op_data), .status(status));
    spi_host host (.clk(clk), .so(so_line), .sck(sck), .si(si), .ce_n(ce_n), .hold_n(hold_n));

    always #25 clk = ~clk;
    // Record each operation the array side takes
    always @(negedge clk) begin
        if (op_valid === 1'b1 && op_ready === 1'b1) begin
            last_op <= op_data;
            got_ops <= got_ops + 1;
        end
    end
    // Runaway guard, over four times the roughly nine thousand clocks the tests need
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt = error_cnt + 1;
            stop_test();
        end
    end
    task automatic check(input logic [34:0] got, input logic [34:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One frame: opcode then nb bytes taken from the top of tail
    task automatic cmd(input logic [7:0] op, input int nb, input logic [31:0] tail);
        logic [7:0] junk;
        host.open_frame();
        host.xfer(op, junk);
        for (int k = 0; k < nb; k++) host.xfer(tail[31-8*k -: 8], junk);
        host.close_frame();
    endtask
    task automatic rd_status(input logic [7:0] exp);
        host.open_frame();
        host.xfer(OP_RDSR, rx);
        host.xfer(8'h00, rx);
        host.close_frame();
        check(35'(rx), 35'(exp));
    endtask
    task automatic stop_test();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        repeat (6) @(posedge clk);
        @(negedge clk);
        check(35'(status), 35'h1c);
        check(35'(so_oe), 35'h0);
        @(posedge clk);
        rd_status(8'h1c);
        host.set_mode(1'b1);
        rd_status(8'h1c);
        host.set_mode(1'b0);
        // Chip erase must be refused while protection bits are set
        cmd(OP_WREN, 0, 32'h0);
        cmd(OP_CHIP, 0, 32'h0);
        check(35'(got_ops), 35'h0);
        for (int j = 0; j < 3; j++) begin
            cmd(OP_WREN, 0, 32'h0);
            cmd(eop[j], 3, 32'h1f5abc00);
            check(35'({last_op.kind, last_op.addr}),
                35'({ek[j], 24'h1f5abc & ~24'(esz[j] - 1)}));
        end
        check(35'(got_ops), 35'h3);
        busy_in <= 1'b1;
        rd_status(8'h1d);
        busy_in <= 1'b0;
        // Clock wiggles during a pause must not shift the read
        host.open_frame();
        host.xfer(OP_RDSR, rx);
        host.pause_on();
        check(35'(so_oe), 35'h0);
        host.xfer(8'hff, rx);
        host.pause_off();
        host.xfer(8'h00, rx);
        host.close_frame();
        check(35'(rx), 35'h1c);
        // Lock-down bit only counts with the protect pin low
        cmd(OP_WREN, 0, 32'h0);
        cmd(OP_WRSR, 1, 32'h80000000);
        check(35'(status), 35'h80);
        wp_n <= 1'b0;
        cmd(OP_WREN, 0, 32'h0);
        cmd(OP_WRSR, 1, 32'h0);
        check(35'(status[7:2]), 35'h20);
        wp_n <= 1'b1;
        cmd(OP_WREN, 0, 32'h0);
        cmd(OP_WRSR, 1, 32'h0);
        check(35'(status), 35'h0);
        cmd(OP_WREN, 0, 32'h0);
        cmd(OP_CHIP, 0, 32'h0);
        check(35'({last_op.kind, last_op.addr}), 35'({K_CHIP, 24'h0}));
        // Busy shown on the output pin during auto-increment
        cmd(OP_EBSY, 0, 32'h0);
        cmd(OP_WREN, 0, 32'h0);
        cmd(OP_AUTO_INCREMENT_PROGRAM, 4, 32'h0001005a);
        check(35'(last_op), 35'({K_PROG, 24'h000100, 8'h5a}));
        host.open_frame();
        busy_in <= 1'b1;
        repeat (6) @(posedge clk);
        @(negedge clk);
        check(35'({so_oe, so}), 35'h2);
        @(posedge clk);
        busy_in <= 1'b0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        check(35'({so_oe, so}), 35'h3);
        @(posedge clk);
        host.close_frame();
        cmd(OP_WRDI, 0, 32'h0);
        cmd(OP_DBSY, 0, 32'h0);
        rd_status(8'h00);
        // Deselect during a pause drops the frame; resuming needs a fresh select
        host.open_frame();
        host.pause_on();
        host.close_frame();
        host.open_frame();
        host.pause_off();
        host.xfer(OP_WREN, rx);
        host.close_frame();
        check(35'(status), 35'h0);
        // Deselected: a full byte of clocks must change nothing
        host.xfer(OP_WREN, rx);
        check(35'(status), 35'h0);
        check(35'(so_oe), 35'h0);
        stop_test();
    end
endmodule
`default_nettype wire
